// ---- rcr_defs.vh ----
/*
  constants for the rail control register bank: offsets, fields, resets.
  assumes inclusion by rcr_rail_control_registers.v and rcr_rail_ctl.v.
*/
`ifndef RCR_DEFS_VH
`define RCR_DEFS_VH

`define RCR_ADDR_IO        8'h30
`define RCR_ADDR_R5        8'h31
`define RCR_ADDR_R33       8'h32
`define RCR_RST_IO         8'h0a
`define RCR_RST_R5         8'h2a
`define RCR_RST_R33        8'h2a
`define RCR_IO_WMASK       8'h7f
`define RCR_MODE_LSB       0
`define RCR_WAKE_LSB       2
`define RCR_VSEL_LSB       4
`define RCR_LPSP_LSB       6
`define RCR_DECAY_BIT      6
`define RCR_MODE_OFF       2'h0
`define RCR_MODE_FORCED_PWM      2'h3
`define RCR_WAKE_NONE      2'h0
`define RCR_LP_OFF         2'h0
`define RCR_RECOVER_NS     2000
`define RCR_CLK_NS         5

`endif

// ---- rcr_rail_ctl.v ----
/*
  one rail's control byte with wake-mode copy and standby set point.
  assumes standby edges come already synchronised on i_clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rcr_defs.vh"
module rcr_rail_ctl #(
  parameter [7:0] RST_VAL = 8'h2a,
  parameter [7:0] WMASK   = 8'hff
) (
  input  wire       i_clk,
  input  wire       i_rst_n,
  input  wire       i_wr,
  input  wire [7:0] i_wdata,
  input  wire       i_sb_rise,
  input  wire       i_sb_fall,
  output reg  [7:0] o_reg,
  output reg  [1:0] o_eff_vsel,
  output reg  [1:0] o_eff_lp,
  output reg        o_lp_active
);
  reg [7:0] reg_d;
  wire [1:0] wake_mode = o_reg[`RCR_WAKE_LSB+1:`RCR_WAKE_LSB];

  always @*
  begin
    reg_d = o_reg;
    if (i_wr)
      reg_d = i_wdata & WMASK;
    // wake-mode copy on standby exit wins over a same-cycle write
    if (i_sb_rise && wake_mode != `RCR_WAKE_NONE)
      reg_d[`RCR_MODE_LSB+1:`RCR_MODE_LSB] = wake_mode;
  end

  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_reg       <= RST_VAL;
      o_eff_vsel  <= RST_VAL[`RCR_VSEL_LSB+1:`RCR_VSEL_LSB];
      o_eff_lp    <= 2'h0;
      o_lp_active <= 1'b0;
    end
    else
    begin
      o_reg      <= reg_d;
      o_eff_vsel <= reg_d[`RCR_VSEL_LSB+1:`RCR_VSEL_LSB];
      // low-power set point latched at standby entry
      if (i_sb_fall)
      begin
        o_eff_lp    <= reg_d[`RCR_LPSP_LSB+1:`RCR_LPSP_LSB];
        o_lp_active <= 1'b1;
      end
      else if (i_sb_rise)
      begin
        o_eff_lp    <= `RCR_LP_OFF;
        o_lp_active <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- rcr_rail_control_registers.v ----
/*
  register bank for the io, 5 v and 3.3 v rail controls.
  assumes a byte register port from the i2c slave on i_clk; standby pin async.
*/
// Contract
// - mode 00 off, 01/10 automatic switching, 11 forced pwm.
// - standby exit copies nonzero wake mode into mode bits; 00 leaves them.
// - decay enabled and standby low: io rail to 0 v, power good kept.
// - decay disabled: io rail stays at its selected voltage.
// - io voltage select 00 0.975, 01 0.950, 10 0.875, 11 0.850 v.
// - 5 v select 00 +3%, 01 +2%, 10 nominal, 11 -2%.
// - standby entry applies low-power set point 00 none, -4%, -3%, -2%.
// - 3.3 v rail uses the 5 v rail encodings.
`timescale 1ns/100ps
`default_nettype none
`include "rcr_defs.vh"
module rcr_rail_control_registers (
  input  wire       i_clk,
  input  wire       i_rst_n,
  input  wire       i_standby_request_n,
  input  wire       i_wr,
  input  wire       i_rd,
  input  wire [7:0] i_addr,
  input  wire [7:0] i_wdata,
  output reg  [7:0] o_rdata,
  output reg        o_rvalid,
  output wire [1:0] o_io_rail_mode,
  output reg  [1:0] o_io_rail_voltage_select,
  output reg        o_io_rail_decay,
  output reg        o_io_power_good_hold,
  output reg        o_io_recover_ok,
  output wire [1:0] o_rail5_mode,
  output wire [1:0] o_rail5_voltage_select,
  output wire [1:0] o_rail5_lowpower_setpoint,
  output wire       o_rail5_lp_active,
  output wire [1:0] o_rail33_mode,
  output wire [1:0] o_rail33_voltage_select,
  output wire [1:0] o_rail33_lowpower_setpoint,
  output wire       o_rail33_lp_active,
  output reg        o_standby_low_state
);
  localparam integer RECOVER_CYC_I = (`RCR_RECOVER_NS + `RCR_CLK_NS - 1) / `RCR_CLK_NS;
  localparam [8:0]   RECOVER_CYC   = RECOVER_CYC_I[8:0];

  function is_addr;
    input [7:0] a;
    input [7:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  reg sb_meta_q;
  reg sb_sync_q;
  reg sb_prev_q;
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      sb_meta_q <= 1'b1;
      sb_sync_q <= 1'b1;
      sb_prev_q <= 1'b1;
    end
    else
    begin
      sb_meta_q <= i_standby_request_n;
      sb_sync_q <= sb_meta_q;
      sb_prev_q <= sb_sync_q;
    end
  end
  wire sb_rise = sb_sync_q & ~sb_prev_q;
  wire sb_fall = ~sb_sync_q & sb_prev_q;

  wire [7:0] io_reg;
  wire [7:0] r5_reg;
  wire [7:0] r33_reg;
  wire [1:0] io_vsel_w;

  rcr_rail_ctl #(.RST_VAL(`RCR_RST_IO), .WMASK(`RCR_IO_WMASK)) u_io (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_wr        (i_wr && is_addr(i_addr, `RCR_ADDR_IO)),
    .i_wdata     (i_wdata),
    .i_sb_rise   (sb_rise),
    .i_sb_fall   (sb_fall),
    .o_reg       (io_reg),
    .o_eff_vsel  (io_vsel_w),
    .o_eff_lp    (),
    .o_lp_active ()
  );
  rcr_rail_ctl #(.RST_VAL(`RCR_RST_R5), .WMASK(8'hff)) u_r5 (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_wr        (i_wr && is_addr(i_addr, `RCR_ADDR_R5)),
    .i_wdata     (i_wdata),
    .i_sb_rise   (sb_rise),
    .i_sb_fall   (sb_fall),
    .o_reg       (r5_reg),
    .o_eff_vsel  (o_rail5_voltage_select),
    .o_eff_lp    (o_rail5_lowpower_setpoint),
    .o_lp_active (o_rail5_lp_active)
  );
  rcr_rail_ctl #(.RST_VAL(`RCR_RST_R33), .WMASK(8'hff)) u_r33 (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_wr        (i_wr && is_addr(i_addr, `RCR_ADDR_R33)),
    .i_wdata     (i_wdata),
    .i_sb_rise   (sb_rise),
    .i_sb_fall   (sb_fall),
    .o_reg       (r33_reg),
    .o_eff_vsel  (o_rail33_voltage_select),
    .o_eff_lp    (o_rail33_lowpower_setpoint),
    .o_lp_active (o_rail33_lp_active)
  );

  // mode fields drive the converters directly
  assign o_io_rail_mode = io_reg[`RCR_MODE_LSB+1:`RCR_MODE_LSB];
  assign o_rail5_mode   = r5_reg[`RCR_MODE_LSB+1:`RCR_MODE_LSB];
  assign o_rail33_mode  = r33_reg[`RCR_MODE_LSB+1:`RCR_MODE_LSB];

  // time since the io rail left forced pwm
  reg [8:0] rec_cnt_q;
  reg       forced_pwm_prev_q;
  wire      decay_en  = io_reg[`RCR_DECAY_BIT];
  wire      sb_low    = ~sb_sync_q;
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_io_rail_voltage_select <= 2'h0;
      o_io_rail_decay          <= 1'b0;
      o_io_power_good_hold     <= 1'b0;
      o_standby_low_state      <= 1'b0;
      o_io_recover_ok          <= 1'b1;
      rec_cnt_q                <= RECOVER_CYC;
      forced_pwm_prev_q              <= 1'b0;
    end
    else
    begin
      o_io_rail_voltage_select <= io_vsel_w;
      o_io_rail_decay          <= decay_en & sb_low;
      o_io_power_good_hold     <= decay_en & sb_low;
      o_standby_low_state      <= sb_low;
      forced_pwm_prev_q <= (o_io_rail_mode == `RCR_MODE_FORCED_PWM);
      // flags once the io rail has been out of forced pwm for RECOVER_CYC cycles
      if (o_io_rail_mode == `RCR_MODE_FORCED_PWM)
        rec_cnt_q <= 9'h000;
      else if (rec_cnt_q != RECOVER_CYC)
        rec_cnt_q <= rec_cnt_q + 9'h001;
      o_io_recover_ok <= (rec_cnt_q == RECOVER_CYC) && !forced_pwm_prev_q;
    end
  end

  // register read port, unmapped reads 00
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_rdata  <= 8'h00;
      o_rvalid <= 1'b0;
    end
    else
    begin
      o_rvalid <= i_rd;
      if (i_rd)
      begin
        if (is_addr(i_addr, `RCR_ADDR_IO))
          o_rdata <= io_reg;
        else if (is_addr(i_addr, `RCR_ADDR_R5))
          o_rdata <= r5_reg;
        else if (is_addr(i_addr, `RCR_ADDR_R33))
          o_rdata <= r33_reg;
        else
          o_rdata <= 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

// ---- rcr_monitor.sv ----
/* checker for the rail bank ports.
   assumes binding onto rcr_rail_control_registers. */
`timescale 1ns/100ps
`default_nettype none
module rcr_monitor (
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       i_rd,
  input wire logic       i_standby_request_n,
  input wire logic       o_rvalid,
  input wire logic       o_io_rail_decay,
  input wire logic       o_io_power_good_hold,
  input wire logic       o_standby_low_state,
  input wire logic       o_rail5_lp_active,
  input wire logic [1:0] o_rail5_lowpower_setpoint
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_read_answer: assert property (i_rd |=> o_rvalid)
    else $error("read unanswered");
  a_sync_entry: assert property ($fell(i_standby_request_n) |-> ##[1:4] o_standby_low_state)
    else $error("standby late");
  a_decay_pg: assert property (o_io_rail_decay == o_io_power_good_hold)
    else $error("power good lost");
  a_decay_cause: assert property ($rose(o_io_rail_decay) |-> !$past(i_standby_request_n))
    else $error("decay uncaused");
  a_decay_exit: assert property ($rose(i_standby_request_n) |-> ##[1:4] !o_io_rail_decay)
    else $error("decay stuck");
  a_lp_cause: assert property ($rose(o_rail5_lp_active) |-> !$past(i_standby_request_n))
    else $error("lp uncaused");
  a_lp_exit: assert property ($rose(i_standby_request_n) |-> ##[1:4] !o_rail5_lp_active)
    else $error("lp stuck");
  a_lp_idle: assert property (!o_rail5_lp_active |-> o_rail5_lowpower_setpoint == 2'h0)
    else $error("lp point set");
endmodule
bind rcr_rail_control_registers rcr_monitor rcr_monitor_i (.*);
`default_nettype wire

// ---- rcr_sb_host.sv ----
/* standby pin source of the host side.
   assumes one clock shared with the bench. */
`timescale 1ns/100ps
`default_nettype none
module rcr_sb_host (
  input  wire logic i_clk,
  input  wire logic i_sleep,
  output var logic  o_standby_request_n
);
  initial o_standby_request_n = 1'b1;
  always @(posedge i_clk) o_standby_request_n <= !i_sleep;
endmodule
`default_nettype wire

// ---- tb.sv ----
/* bench for the rail bank.
   assumes 200 mhz clock and the standby source model. */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic       clk = 0, rst_n = 0, wr = 0, rd = 0, slp_r = 0;
  logic [7:0] addr = 8'h00, wd = 8'h00;
  wire  [7:0] rdat;
  wire        rv, sb_n, lst, dec, pgh, rok, lpa5, lpa33;
  wire  [1:0] mio, vio, m5, v5, lp5, lp33, m33, v33;
  int         miscompares = 0, n_compared = 0;
  always #2.5 clk = !clk;
  rcr_sb_host rcr_sb_host_i (.i_clk(clk), .i_sleep(slp_r), .o_standby_request_n(sb_n));
  rcr_rail_control_registers rcr_rail_control_registers_i (.i_clk(clk), .i_rst_n(rst_n),
    .i_standby_request_n(sb_n), .i_wr(wr), .i_rd(rd), .i_addr(addr), .i_wdata(wd),
    .o_rdata(rdat), .o_rvalid(rv), .o_io_rail_mode(mio), .o_io_rail_voltage_select(vio),
    .o_io_rail_decay(dec), .o_io_power_good_hold(pgh), .o_io_recover_ok(rok),
    .o_rail5_mode(m5), .o_rail5_voltage_select(v5), .o_rail5_lowpower_setpoint(lp5),
    .o_rail5_lp_active(lpa5), .o_rail33_mode(m33), .o_rail33_voltage_select(v33),
    .o_rail33_lowpower_setpoint(lp33), .o_rail33_lp_active(lpa33), .o_standby_low_state(lst));
  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wrb(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd   <= d;
    wr   <= 1'b1;
    @(posedge clk);
    wr   <= 1'b0;
  endtask
  task automatic rdb(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 cmp((rv === 1'b1) ? rdat : 8'hxx, e);
  endtask
  task automatic slp(input logic v);
    int k;
    @(posedge clk);
    slp_r <= v;
    for (k = 0; k < 50 && lst !== v; k++)
      @(posedge clk);
    repeat (4) @(posedge clk);
    #1;
  endtask
  initial
  begin
    #20000;
    miscompares++;
    report_and_stop;
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rdb(8'h30, 8'h0a);
    rdb(8'h31, 8'h2a);
    rdb(8'h32, 8'h2a);
    rdb(8'h33, 8'h00);
    cmp({3'h0, rok, m33, v33}, 8'h1a);
    wrb(8'h30, 8'hff);
    rdb(8'h30, 8'h7f);
    cmp({3'h0, rok, mio, vio}, 8'h0f);
    wrb(8'h30, 8'h46);
    wrb(8'h31, 8'hf3);
    wrb(8'h32, 8'h5d);
    wrb(8'h33, 8'h12);
    rdb(8'h33, 8'h00);
    repeat (400) @(posedge clk);
    #1 cmp({1'b0, rok, mio, m5, v5}, 8'h6f);
    cmp({4'h0, m33, v33}, 8'h05);
    slp(1'b1);
    cmp({lpa5, lpa33, dec, pgh, lp5, lp33}, 8'hfd);
    slp(1'b0);
    rdb(8'h30, 8'h45);
    rdb(8'h31, 8'hf3);
    rdb(8'h32, 8'h5f);
    cmp({1'b0, lpa5, lpa33, dec, lp5, lp33}, 8'h00);
    cmp({4'h0, m33, v33}, 8'h0d);
    wrb(8'h30, 8'h2a);
    slp(1'b1);
    cmp({5'h0, dec, vio}, 8'h02);
    slp(1'b0);
    report_and_stop;
  end
endmodule
`default_nettype wire
